// >>> src/irq_defines.svh
// Purpose: Offsets, field positions and reset values of the irq block.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Included by the design module and the bench top.
//
// What this block does
// - On interrupt entry push the return program counter onto the stack.
// - On entry copy W, status, bank select, pointers, PC latch to shadows.
// - On return reload every shadowed register from its shadow copy.
// - Live register changes made in the service routine are lost on return.
// - Software writing a shadow copy gets that value restored on return, except status bits 4 and 3, which are never kept.
// - Shadow copies sit in data bank 31, readable and writable.
// - Flags set on their event regardless of own or global enable.
// - Global enable bit 7 allows enabled interrupts; zero blocks all.
// - Group enable bit 6 gates every peripheral-register interrupt.
// - Bits 5, 4, 3 enable timer0, external pin, pin change.
// - Bit 2 set by timer0 overflow; software reads and writes it.
// - Bit 1 set by external pin event; software reads and writes it.
// - Bit 0 read-only, one while any pin change is recorded.
// - Enable register 1 holds eight peripheral enables, bit 7 to 0.
// - Enable register 3 holds bits 5, 4, 3, 1 on the larger variant.
// - Enable register 4 holds bits 1, 0 on the larger variant.
// - All enable and flag bits clear on every reset.
// - Unimplemented bits ignore writes and read zero.
// - Accepted interrupt flushes, clears global enable, pushes, saves, vectors.
// - Return pops the address, restores context, sets global enable.
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// Register byte offsets.
`define OFS_CORE_CTL   16'h0000
`define OFS_PEN1       16'h0004
`define OFS_PEN2       16'h0008
`define OFS_PEN3       16'h000C
`define OFS_PEN4       16'h0010
// Shadow bank 31 base, eight words from here.
`define OFS_SHADOW     16'h1F00
`define SHADOW_WORDS   8

// Core control field positions.
`define BIT_GLOBAL_EN  7
`define BIT_GROUP_EN   6
`define BIT_T0IE       5
`define BIT_INTE       4
`define BIT_CHANGE_EN  3
`define BIT_T0IF       2
`define BIT_PIN_FLAG   1
`define BIT_CHANGE_FLAG 0

// Implemented bit masks of the peripheral enable registers.
`define MASK_PEN1      8'hFF
`define MASK_PEN2      8'hF9
`define MASK_PEN3      8'h3A
`define MASK_PEN4      8'h03
// Status bits that are saved and restored; the watchdog and sleep bits are not.
`define MASK_STATUS    8'hE7

// Reset values and vector.
`define RST_BYTE       8'h00
`define IRQ_VECTOR     16'h0004

`endif

// >>> src/irq_pkg.sv
// Purpose: Types shared by the irq block and its bench.
// Assumes: irq_defines.svh holds all numeric constants.
// Notes:   Field order of ctx_t is the shadow word order.
package irq_pkg;

    // Working context of the core that is shadowed.
    typedef struct packed {
        logic [7:0] pc_high;
        logic [7:0] fsr1h;
        logic [7:0] fsr1l;
        logic [7:0] fsr0h;
        logic [7:0] fsr0l;
        logic [7:0] bank_sel;
        logic [7:0] status;
        logic [7:0] w;
    } ctx_t;

    // Peripheral flag registers, level inputs.
    typedef struct packed {
        logic [7:0] p4;
        logic [7:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
    } periph_flags_t;

    // Service state of the core.
    typedef enum logic [0:0] {
        RUNNING    = 1'b0,
        IN_SERVICE = 1'b1
    } svc_state_t;

endpackage

// >>> src/irq_enable_and_context_shadow.sv
// Purpose: Interrupt enable bank, request logic and context shadowing.
// Assumes: Core and event sources run on mclk; APB slave, one wait state.
// Notes:   Core entry and return are single-cycle strobes from the core.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "irq_defines.svh"

module irq_enable_and_context_shadow
    import irq_pkg::*;
#(
    parameter int PC_W          = 15,
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset.
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    // APB slave.
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [15:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Event sources.
    input  wire logic          timer0_ovf,
    input  wire logic          ext_pin_event,
    input  wire logic          pin_change_pending,
    input  periph_flags_t      periph_flags,
    // Core handshake.
    input  wire logic          irq_entry,
    input  wire logic          irq_return,
    input  wire logic [PC_W-1:0] return_pc,
    input  ctx_t               live_ctx,
    output logic               irq_request,
    output logic               flush_prefetch,
    output logic               stack_push,
    output logic [PC_W-1:0]    push_pc,
    output logic               stack_pop,
    output logic               vector_load,
    output logic [15:0]        vector_addr,
    output logic               ctx_restore,
    output ctx_t               restore_ctx
);

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    generate
        if (PC_W < 3 || PC_W > 16) begin : g_bad_pc
            $error("PC_W must lie between 3 and 16.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Storage.

    logic          global_irq_en;
    logic          periph_group_irq_en;
    logic          timer0_ovf_en;
    logic          ext_pin_irq_en;
    logic          pin_change_irq_en;
    logic          timer0_ovf_flag;
    logic          ext_pin_irq_flag;
    logic          pin_change_irq_flag;
    logic [7:0]    pie [4];
    ctx_t          shadow;
    svc_state_t    svc_state;

    logic          wr_en;
    logic          rd_en;
    logic [7:0]    wbyte;
    logic          hit_reg;
    logic          hit_shadow;
    logic [2:0]    shadow_idx;
    logic [7:0]    pie_mask [4];
    logic          accept;
    logic          next_request;
    ctx_t          next_shadow;

    // Shadow word index from a byte address inside bank 31.
    function automatic logic [2:0] shadow_index(input logic [15:0] a);
        return a[4:2];
    endfunction

    // Read one shadow byte by index.
    function automatic logic [7:0] shadow_byte(input ctx_t c,
                                               input logic [2:0] i);
        logic [63:0] flat;
        flat = c;
        return flat[i*8 +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // APB decode. A request is acted on in the access phase, once.

    assign wr_en      = psel && penable && pwrite && !pready;
    assign rd_en      = psel && penable && !pwrite && !pready;
    assign wbyte      = pwdata[7:0];
    assign shadow_idx = shadow_index(paddr);
    assign hit_shadow = (paddr[15:5] == 11'(`OFS_SHADOW >> 5))
                        && (paddr[1:0] == 2'b00);
    assign hit_reg    = (paddr == `OFS_CORE_CTL) || (paddr == `OFS_PEN1)
                        || (paddr == `OFS_PEN2) || (paddr == `OFS_PEN3)
                        || (paddr == `OFS_PEN4);

    // Implemented enable bits; the small variant has no register 3 or 4.
    assign pie_mask[0] = `MASK_PEN1;
    assign pie_mask[1] = `MASK_PEN2;
    assign pie_mask[2] = LARGE_VARIANT ? `MASK_PEN3 : 8'h00;
    assign pie_mask[3] = LARGE_VARIANT ? `MASK_PEN4 : 8'h00;

    // Entry is honoured only while the global enable is set.
    // A strobe that comes while it is clear is dropped; the flag that
    // caused it stays set and is served once the enable returns.
    assign accept = irq_entry && global_irq_en;

    ////////////////////////////////////////////////////////////////////
    // APB answer: pready one cycle into the access phase.
    // Reads and writes act once, in the first access cycle; pready then
    // closes the access, so every transfer has exactly one wait state.

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit_reg && !hit_shadow;
            if (rd_en) begin
                prdata <= 32'h0000_0000;
                if (hit_shadow) begin
                    prdata[7:0] <= shadow_byte(shadow, shadow_idx);
                end else begin
                    unique case (paddr)
                        `OFS_CORE_CTL: prdata[7:0] <= {global_irq_en,
                            periph_group_irq_en, timer0_ovf_en,
                            ext_pin_irq_en, pin_change_irq_en,
                            timer0_ovf_flag, ext_pin_irq_flag,
                            pin_change_irq_flag};
                        `OFS_PEN1: prdata[7:0] <= pie[0] & pie_mask[0];
                        `OFS_PEN2: prdata[7:0] <= pie[1] & pie_mask[1];
                        `OFS_PEN3: prdata[7:0] <= pie[2] & pie_mask[2];
                        `OFS_PEN4: prdata[7:0] <= pie[3] & pie_mask[3];
                        default:   prdata[7:0] <= 8'h00;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Global enable: cleared on entry, set on return, else software.

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            global_irq_en <= 1'b0;
        end else if (accept) begin
            global_irq_en <= 1'b0;
        end else if (irq_return && svc_state == IN_SERVICE) begin
            global_irq_en <= 1'b1;
        end else if (wr_en && paddr == `OFS_CORE_CTL) begin
            global_irq_en <= wbyte[`BIT_GLOBAL_EN];
        end
    end

    // Core enables, plain read and write.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            periph_group_irq_en <= 1'b0;
            timer0_ovf_en       <= 1'b0;
            ext_pin_irq_en      <= 1'b0;
            pin_change_irq_en   <= 1'b0;
        end else if (wr_en && paddr == `OFS_CORE_CTL) begin
            periph_group_irq_en <= wbyte[`BIT_GROUP_EN];
            timer0_ovf_en       <= wbyte[`BIT_T0IE];
            ext_pin_irq_en      <= wbyte[`BIT_INTE];
            pin_change_irq_en   <= wbyte[`BIT_CHANGE_EN];
        end
    end

    // Core flags: a hardware event wins over a software clear.
    // Letting the clear win in that cycle would lose the event for good,
    // so software at worst sees the flag again and serves it twice.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer0_ovf_flag  <= 1'b0;
            ext_pin_irq_flag <= 1'b0;
        end else begin
            if (timer0_ovf) begin
                timer0_ovf_flag <= 1'b1;
            end else if (wr_en && paddr == `OFS_CORE_CTL) begin
                timer0_ovf_flag <= wbyte[`BIT_T0IF];
            end
            if (ext_pin_event) begin
                ext_pin_irq_flag <= 1'b1;
            end else if (wr_en && paddr == `OFS_CORE_CTL) begin
                ext_pin_irq_flag <= wbyte[`BIT_PIN_FLAG];
            end
        end
    end

    // Pin change flag follows the pending level; writes do not touch it.
    // Software clears the recorded changes at their source, not here.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_change_irq_flag <= 1'b0;
        end else begin
            pin_change_irq_flag <= pin_change_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Peripheral enable registers; only implemented bits are stored.

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                pie[i] <= `RST_BYTE;
            end
        end else if (wr_en) begin
            for (int i = 0; i < 4; i++) begin
                if (paddr == `OFS_PEN1 + 16'(i * 4)) begin
                    pie[i] <= wbyte & pie_mask[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request forming.
    // The request leaves from a flip-flop; its input is held low in the cycle
    // of an accepted entry, so the core sees the request low from the next cycle.

    always_comb begin
        logic periph_hit;
        periph_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            periph_hit = periph_hit
                | (|(pie[i] & pie_mask[i] & periph_flags[i*8 +: 8]));
        end
        next_request = global_irq_en && !accept
            && ((timer0_ovf_en && timer0_ovf_flag)
                || (ext_pin_irq_en && ext_pin_irq_flag)
                || (pin_change_irq_en && pin_change_irq_flag)
                || (periph_group_irq_en && periph_hit));
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= next_request;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Service state: entry opens it, return closes it.

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            svc_state <= RUNNING;
        end else begin
            unique case (svc_state)
                RUNNING: begin
                    if (accept) begin
                        svc_state <= IN_SERVICE;
                    end
                end
                IN_SERVICE: begin
                    if (irq_return) begin
                        svc_state <= RUNNING;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shadow copies: captured on entry, else written by software.
    // A software write lands in the copy that the next return restores;
    // the watchdog and sleep bits are never kept in the status copy.

    always_comb begin
        logic [63:0] flat;
        flat = shadow;
        if (wr_en && hit_shadow) begin
            flat[shadow_idx*8 +: 8] = wbyte;
        end
        next_shadow = flat;
        if (accept) begin
            next_shadow        = live_ctx;
            next_shadow.status = live_ctx.status & `MASK_STATUS;
        end
        next_shadow.status = next_shadow.status & `MASK_STATUS;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shadow <= '0;
        end else begin
            shadow <= next_shadow;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Entry strobes toward the core and the return stack.

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flush_prefetch <= 1'b0;
            stack_push     <= 1'b0;
            push_pc        <= '0;
            vector_load    <= 1'b0;
            vector_addr    <= 16'h0000;
        end else begin
            flush_prefetch <= accept;
            stack_push     <= accept;
            vector_load    <= accept;
            if (accept) begin
                push_pc     <= return_pc;
                vector_addr <= `IRQ_VECTOR;
            end
        end
    end

    // Return strobes: pop and restore the shadow, live edits are lost.
    // A return while not in service is ignored, so a stray strobe cannot
    // pop the stack or restore a stale context.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stack_pop   <= 1'b0;
            ctx_restore <= 1'b0;
            restore_ctx <= '0;
        end else begin
            stack_pop   <= irq_return && svc_state == IN_SERVICE;
            ctx_restore <= irq_return && svc_state == IN_SERVICE;
            if (irq_return && svc_state == IN_SERVICE) begin
                restore_ctx <= shadow;
            end
        end
    end

endmodule

// >>> sim/irq_shadow_chk.sv
// Purpose: Concurrent checks on the ports of the irq block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
////////////////////////////////////////
module irq_shadow_chk
    import irq_pkg::*;
#(
    parameter int PC_W = 15
) (
    // Clock and reset.
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    // Register bus.
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic [31:0]     prdata,
    input  wire logic            pready,
    input  wire logic            pslverr,
    // Core handshake.
    input  wire logic            irq_entry,
    input  wire logic            irq_return,
    input  wire logic [PC_W-1:0] return_pc,
    input  wire logic            irq_request,
    input  wire logic            flush_prefetch,
    input  wire logic            stack_push,
    input  wire logic [PC_W-1:0] push_pc,
    input  wire logic            stack_pop,
    input  wire logic            vector_load,
    input  wire logic [15:0]     vector_addr,
    input  wire logic            ctx_restore,
    input  ctx_t                 restore_ctx
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Entry and return each take one core strobe and one answer cycle.
    sequence entry_s;
        irq_entry ##1 flush_prefetch;
    endsequence
    sequence return_s;
        irq_return ##1 ctx_restore;
    endsequence

    entry_answer_a:
        assert property (entry_s |-> stack_push && vector_load
            && vector_addr == 16'h0004 && !irq_request)
        else $error("Entry strobes or vector wrong.");
    entry_cause_a:
        assert property (flush_prefetch |-> $past(irq_entry)
            && push_pc == $past(return_pc))
        else $error("Entry without cause or wrong pushed address.");
    entry_pulse_a:
        assert property (entry_s |=> !flush_prefetch && !stack_push)
        else $error("Entry strobes longer than one cycle.");
    return_cause_a:
        assert property (ctx_restore |-> stack_pop && $past(irq_return))
        else $error("Restore without return or without pop.");
    return_pulse_a:
        assert property (return_s |=> !ctx_restore
            && $stable(restore_ctx))
        else $error("Restore pulse or restored value unstable.");
    status_mask_a:
        assert property (ctx_restore |-> restore_ctx.status[4:3] == 2'b00)
        else $error("Watchdog or sleep bit restored.");
    bus_wait_a:
        assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("Bus answer not after one wait state.");
    bus_error_a:
        assert property (pready |-> prdata[31:8] == 24'h00_0000
            or (pslverr && prdata == 32'h0000_0000))
        else $error("Upper read bits not zero.");
endmodule

bind irq_enable_and_context_shadow irq_shadow_chk #(.PC_W(PC_W)) u_chk (
    .mclk, .sys_rst, .psel, .penable, .prdata, .pready, .pslverr,
    .irq_entry, .irq_return, .return_pc, .irq_request, .flush_prefetch,
    .stack_push, .push_pc, .stack_pop, .vector_load, .vector_addr,
    .ctx_restore, .restore_ctx);

// >>> sim/core_model.sv
// Purpose: Core side of the irq block: entry and return strobes.
// Assumes: Runs on mclk; the bench picks lag, context and address.
// Notes:   Enters only on a standing request, after lag cycles.
`timescale 1ns/1ps
////////////////////////////////////////
module core_model
    import irq_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Block side.
    input  wire logic        irq_request,
    output logic             irq_entry,
    output logic             irq_return,
    output logic [14:0]      return_pc,
    output ctx_t             live_ctx,
    // Bench control.
    input  wire logic        ret_go,
    input  wire logic [15:0] lag,
    input  wire logic [14:0] pc_seed,
    input  ctx_t             ctx_seed
);
    logic        busy;
    logic [15:0] cnt;

    // Context and return address are what the core holds right now.
    assign live_ctx  = ctx_seed;
    assign return_pc = pc_seed;

    // A request must stand for lag cycles; a dropped one restarts it.
    always_ff @(posedge mclk) begin
        irq_entry  <= 1'b0;
        irq_return <= 1'b0;
        if (sys_rst) begin
            busy <= 1'b0;
            cnt  <= 16'h0000;
        end else if (!busy && irq_request) begin
            cnt <= cnt + 16'h0001;
            if (cnt >= lag) begin
                irq_entry <= 1'b1;
                busy      <= 1'b1;
            end
        end else if (busy && ret_go) begin
            irq_return <= 1'b1;
            busy       <= 1'b0;
        end else begin
            cnt <= 16'h0000;
        end
    end
endmodule

// >>> sim/irq_enable_and_context_shadow_tb_top.sv
// Purpose: Self-checking bench of the irq enable and shadow block.
// Assumes: APB master here, core_model plays the processor core.
// Notes:   The core is kept slow until the context test.
`timescale 1ns/1ps
`include "irq_defines.svh"
////////////////////////////////////////
module irq_enable_and_context_shadow_tb_top
    import irq_pkg::*;
;
    logic          mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [15:0]   paddr, vector_addr, lag;
    logic [31:0]   pwdata, prdata;
    logic          timer0_ovf, ext_pin_event, pin_change_pending, ret_go;
    logic          irq_entry, irq_return, irq_request, flush_prefetch;
    logic          stack_push, stack_pop, vector_load, ctx_restore, err;
    logic [14:0]   return_pc, push_pc, pc_seed;
    logic [7:0]    rd;
    periph_flags_t periph_flags;
    ctx_t          live_ctx, restore_ctx, ctx_seed;
    int            error_cnt, tests_run, cycles;

    // Block under test and the core that serves its requests.
    irq_enable_and_context_shadow DUT (.mclk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer0_ovf,
        .ext_pin_event, .pin_change_pending, .periph_flags, .irq_entry,
        .irq_return, .return_pc, .live_ctx, .irq_request, .flush_prefetch,
        .stack_push, .push_pc, .stack_pop, .vector_load, .vector_addr,
        .ctx_restore, .restore_ctx);
    core_model u_core (.mclk, .sys_rst, .irq_request, .irq_entry,
        .irq_return, .return_pc, .live_ctx, .ret_go, .lag, .pc_seed,
        .ctx_seed);

    // Clock, and a cycle limit that cuts a hang short.
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [63:0] seen, want);
        tests_run++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, want, seen);
        end
    endtask

    // One APB transfer, then an idle cycle; a read is compared.
    task automatic acc(input logic wr, input logic [15:0] a,
                       input logic [7:0] d, want, input string nm);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (!wr) chk(nm, rd, want);
    endtask

    // Waits a bounded time for the entry or the return strobe.
    task automatic wait_for(input bit on_return);
        int n;
        n = 0;
        while ((on_return ? ctx_restore : flush_prefetch) !== 1'b1
               && n < 50) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // Reset values, implemented bits and an unmapped address.
    task automatic t_regs();
        logic [15:0] a[5];
        logic [7:0]  m[5];
        a = '{`OFS_CORE_CTL, `OFS_PEN1, `OFS_PEN2, `OFS_PEN3, `OFS_PEN4};
        m = '{8'hFE, 8'hFF, 8'hF9, 8'h3A, 8'h03};
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, a[i], 8'h00, 8'h00, "reset value");
            acc(1'b1, a[i], 8'hFF, 8'h00, "");
            acc(1'b0, a[i], 8'h00, m[i], "bits");
            acc(1'b1, a[i], 8'h00, 8'h00, "");
        end
        acc(1'b0, 16'h0014, 8'h00, 8'h00, "unmapped read");
        chk("unmapped error", err, 1'b1);
        $display("Test registers finished");
    endtask

    // Flags without enables, then request gating by each enable level.
    task automatic t_flags();
        timer0_ovf <= 1'b1;
        ext_pin_event <= 1'b1;
        pin_change_pending <= 1'b1;
        @(posedge mclk);
        timer0_ovf <= 1'b0;
        ext_pin_event <= 1'b0;
        acc(1'b0, `OFS_CORE_CTL, 8'h00, 8'h07, "flags");
        acc(1'b1, `OFS_CORE_CTL, 8'h00, 8'h00, "");
        acc(1'b0, `OFS_CORE_CTL, 8'h00, 8'h01, "cleared");
        acc(1'b1, `OFS_CORE_CTL, 8'h08, 8'h00, "");
        chk("request, global off", irq_request, 1'b0);
        acc(1'b1, `OFS_CORE_CTL, 8'h88, 8'h00, "");
        chk("request, global on", irq_request, 1'b1);
        pin_change_pending <= 1'b0;
        periph_flags.p1 <= 8'h01;
        acc(1'b1, `OFS_PEN1, 8'h01, 8'h00, "");
        chk("request, group off", irq_request, 1'b0);
        acc(1'b1, `OFS_CORE_CTL, 8'hC0, 8'h00, "");
        chk("request, group on", irq_request, 1'b1);
        acc(1'b1, `OFS_CORE_CTL, 8'h40, 8'h00, "");
        chk("request, group only", irq_request, 1'b0);
        periph_flags.p1 <= 8'h00;
        acc(1'b1, `OFS_PEN1, 8'h00, 8'h00, "");
        ext_pin_event <= 1'b1;
        @(posedge mclk);
        ext_pin_event <= 1'b0;
        acc(1'b1, `OFS_CORE_CTL, 8'h92, 8'h00, "");
        chk("request, pin", irq_request, 1'b1);
        acc(1'b1, `OFS_CORE_CTL, 8'h00, 8'h00, "");
        $display("Test flags finished");
    endtask

    // Entry saves context, a shadow write survives, return restores it.
    task automatic t_ctx();
        ctx_seed <= 64'h8877_6655_4433_FF11;
        pc_seed <= 15'h0123;
        lag <= 16'h0003;
        acc(1'b1, `OFS_CORE_CTL, 8'hA0, 8'h00, "");
        timer0_ovf <= 1'b1;
        @(posedge mclk);
        timer0_ovf <= 1'b0;
        wait_for(1'b0);
        chk("entry strobes", {stack_push, vector_load}, 2'b11);
        chk("pushed address", push_pc, 15'h0123);
        chk("vector", vector_addr, 16'h0004);
        ctx_seed <= 64'h0000_0000_0000_0000;
        acc(1'b0, `OFS_CORE_CTL, 8'h00, 8'h24, "in service");
        acc(1'b0, `OFS_SHADOW + 16'h0004, 8'h00, 8'hE7, "status");
        acc(1'b0, `OFS_SHADOW + 16'h001C, 8'h00, 8'h88, "latch");
        acc(1'b1, `OFS_SHADOW, 8'h5A, 8'h00, "");
        acc(1'b1, `OFS_CORE_CTL, 8'h20, 8'h00, "");
        ret_go <= 1'b1;
        @(posedge mclk);
        ret_go <= 1'b0;
        wait_for(1'b1);
        chk("return strobes", stack_pop, 1'b1);
        chk("restored", restore_ctx, 64'h8877_6655_4433_E75A);
        acc(1'b0, `OFS_CORE_CTL, 8'h00, 8'hA0, "after return");
        $display("Test context finished");
    endtask

    // A reset in mid-run clears enables, flags and the shadow copies.
    task automatic t_reset();
        acc(1'b1, `OFS_CORE_CTL, 8'h7E, 8'h00, "");
        acc(1'b1, `OFS_PEN2, 8'hFF, 8'h00, "");
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        acc(1'b0, `OFS_CORE_CTL, 8'h00, 8'h00, "core reset");
        acc(1'b0, `OFS_PEN2, 8'h00, 8'h00, "enable reset");
        acc(1'b0, `OFS_SHADOW + 16'h0004, 8'h00, 8'h00, "shadow");
        chk("vector reset", vector_addr, 16'h0000);
        $display("Test reset finished");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reset for four cycles, then the tests in order.
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, timer0_ovf, ext_pin_event} = '0;
        {pin_change_pending, ret_go, error_cnt, tests_run, cycles} = '0;
        {paddr, pwdata, periph_flags, ctx_seed, pc_seed} = '0;
        lag = 16'h03E8;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_flags();
        t_ctx();
        t_reset();
        stop_test();
    end
endmodule
